// ==== sic_defines.svh ====
// Constants for the sleep, idle and wake-up controller.
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH
`define SIC_ADDR_W         12
`define SIC_REG_REGULATOR  12'h812
`define SIC_REG_DOZE_IDLE  12'h88c
`define SIC_REG_STATUS     12'h880
`define SIC_BIT_REG_PM     1
`define SIC_BIT_IDLE       7
`define SIC_BIT_DOZE_ENABLE_BIT      6
`define SIC_BIT_ROI        5
`define SIC_BIT_DOE        4
`define SIC_ISR_VECTOR     15'h0004
`define SIC_OST_PERIODS    1024
`define SIC_LP_DELAY       16
`endif

// ==== sic_pkg.sv ====
// Types for the sleep, idle and wake-up controller.
package sic_pkg;
  typedef enum logic [2:0] {
    SIC_RUN,
    SIC_SLEEP,
    SIC_IDLE,
    SIC_WAKE_DELAY,
    SIC_RESUME
  } sic_state_t;

  typedef struct packed {
    logic clk_cpu_en;
    logic clk_sys_en;
    logic clk_out_en;
    logic reg_lowpower;
  } sic_clk_ctrl_t;
endpackage

// ==== sic_power_ctrl.sv ====
// Power-mode controller: sleep, idle, wake and clock gating.
`timescale 1ns/10ps
`include "sic_defines.svh"
module sic_power_ctrl
  import sic_pkg::*;
#(
  parameter int OST_CYCLES = `SIC_OST_PERIODS,
  parameter int LP_CYCLES  = `SIC_LP_DELAY,
  parameter bit REGULATED  = 1'b1
)(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // Register port
  input  wire logic [`SIC_ADDR_W-1:0] addr_in,
  input  wire logic [7:0]             wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [7:0]             rdata_out,
  // CPU core
  input  wire logic                   sleep_exec_in,
  input  wire logic                   global_int_enable_in,
  input  wire logic                   int_pending_in,
  input  wire logic                   clkswitch_int_in,
  input  wire logic                   isr_entry_in,
  output logic                        powerdown_flag_out,
  output logic                        timeout_flag_out,
  output logic                        prefetch_out,
  output logic                        vector_req_out,
  output logic [14:0]                 vector_addr_out,
  output logic                        resume_out,
  // Wake sources and watchdog
  input  wire logic                   windowed_watchdog_in,
  input  wire logic                   crystal_mode_in,
  input  wire logic                   clock_output_enable_n_in,
  output logic                        watchdog_clear_out,
  output logic                        watchdog_reset_out,
  // Clock and regulator controls
  output sic_clk_ctrl_t               clk_ctrl_out,
  output logic                        doze_active_out
);

  sic_state_t state;
  sic_state_t next_state;
  logic       regulator_power_mode;
  logic       idle_select;
  logic       doze_enable_bit;
  logic       recover_on_interrupt;
  logic       doze_on_exit;
  logic [2:0] doze_ratio;
  logic [10:0] wait_cnt;
  logic       wdt_sync1;
  logic       wdt_sync2;
  logic       wake_int;
  logic       lp_sleep;
  logic       int_wake;
  logic       gie_at_wake;
  logic       wdt_absorbed;

  // -------------------------------------------------------------------------
  // Wake source qualification
  // -------------------------------------------------------------------------
  // The watchdog arrives from its own oscillator, so it is synchronised.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wdt_sync1 <= 1'b0;
      wdt_sync2 <= 1'b0;
    end
    else
    begin
      wdt_sync1 <= windowed_watchdog_in;
      wdt_sync2 <= wdt_sync1;
    end
  end

  // Pending interrupt already gated by each source's own enable bit.
  assign wake_int = int_pending_in & ~clkswitch_int_in;
  assign lp_sleep = REGULATED & regulator_power_mode;

  // -------------------------------------------------------------------------
  // State machine
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      SIC_RUN:
        if (sleep_exec_in && !(wake_int && !global_int_enable_in))
          next_state = idle_select ? SIC_IDLE : SIC_SLEEP;
      SIC_SLEEP:
        if (wake_int || wdt_sync2)
          next_state = (crystal_mode_in || lp_sleep) ?
                       SIC_WAKE_DELAY : SIC_RESUME;
      SIC_IDLE:
        if (wake_int || wdt_sync2)
          next_state = SIC_RESUME;
      SIC_WAKE_DELAY:
        if (wait_cnt == 11'h000)
          next_state = SIC_RESUME;
      SIC_RESUME:
        next_state = SIC_RUN;
      default:
        next_state = SIC_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state <= SIC_RUN;
    else
      state <= next_state;
  end

  // Stabilisation counter: crystal start-up plus regulator settle time.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_cnt <= 11'h000;
    else if (state == SIC_SLEEP && next_state == SIC_WAKE_DELAY)
      wait_cnt <= 11'((crystal_mode_in ? OST_CYCLES : 0)
                  + (lp_sleep ? LP_CYCLES : 0) - 1);
    else if (state == SIC_WAKE_DELAY && wait_cnt != 11'h000)
      wait_cnt <= wait_cnt - 11'h001;
  end

  // -------------------------------------------------------------------------
  // Status flags and wake bookkeeping
  // -------------------------------------------------------------------------
  // Power-on reset leaves both flags set; a no-operation sleep leaves them.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      powerdown_flag_out <= 1'b1;
      timeout_flag_out   <= 1'b1;
    end
    else if (state == SIC_RUN && next_state == SIC_SLEEP)
    begin
      powerdown_flag_out <= 1'b0;
      timeout_flag_out   <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      int_wake    <= 1'b0;
      gie_at_wake <= 1'b0;
    end
    else if ((state == SIC_SLEEP || state == SIC_IDLE) && next_state != state)
    begin
      int_wake    <= wake_int;
      gie_at_wake <= global_int_enable_in;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs to core and watchdog
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      prefetch_out       <= 1'b0;
      watchdog_clear_out <= 1'b0;
      resume_out         <= 1'b0;
      vector_req_out     <= 1'b0;
      vector_addr_out    <= 15'h0000;
    end
    else
    begin
      prefetch_out       <= sleep_exec_in;
      watchdog_clear_out <= (state == SIC_RUN && next_state == SIC_SLEEP)
                         || (state == SIC_SLEEP && next_state != SIC_SLEEP);
      resume_out         <= (state == SIC_RESUME);
      vector_req_out     <= (state == SIC_RESUME) && int_wake
                         && gie_at_wake;
      vector_addr_out    <= `SIC_ISR_VECTOR;
    end
  end

  // A watchdog event seen while powered down only wakes the device. It is
  // remembered until the level drops, so the same event cannot reset later.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wdt_absorbed <= 1'b0;
    else if (!wdt_sync2)
      wdt_absorbed <= 1'b0;
    else if (state == SIC_IDLE || state == SIC_SLEEP)
      wdt_absorbed <= 1'b1;
  end

  // Watchdog reset passes through except in Idle and Sleep, where it only wakes.
  assign watchdog_reset_out = wdt_sync2 && !wdt_absorbed
                           && state != SIC_IDLE
                           && state != SIC_SLEEP;

  // -------------------------------------------------------------------------
  // Clock and regulator gating
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      clk_ctrl_out <= '{1'b1, 1'b1, 1'b1, 1'b0};
    else
    begin
      clk_ctrl_out.clk_cpu_en   <= next_state == SIC_RUN
                                || next_state == SIC_RESUME;
      clk_ctrl_out.clk_sys_en   <= next_state != SIC_SLEEP
                                && next_state != SIC_WAKE_DELAY;
      clk_ctrl_out.clk_out_en   <= next_state == SIC_IDLE ?
                                   !clock_output_enable_n_in
                                 : next_state != SIC_SLEEP;
      clk_ctrl_out.reg_lowpower <= next_state == SIC_SLEEP && lp_sleep;
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      regulator_power_mode <= 1'b0;
    else if (wr_in && addr_in == `SIC_REG_REGULATOR)
      regulator_power_mode <= wdata_in[`SIC_BIT_REG_PM] & REGULATED;
  end

  // Idle select is left alone by wakes; doze enable follows the ISR bits.
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      idle_select          <= 1'b0;
      doze_enable_bit      <= 1'b0;
      recover_on_interrupt <= 1'b0;
      doze_on_exit         <= 1'b0;
      doze_ratio           <= 3'h0;
    end
    else if (wr_in && addr_in == `SIC_REG_DOZE_IDLE)
    begin
      idle_select          <= wdata_in[`SIC_BIT_IDLE];
      doze_enable_bit      <= wdata_in[`SIC_BIT_DOZE_ENABLE_BIT];
      recover_on_interrupt <= wdata_in[`SIC_BIT_ROI];
      doze_on_exit         <= wdata_in[`SIC_BIT_DOE];
      doze_ratio           <= wdata_in[2:0];
    end
    else if (state == SIC_IDLE && wake_int && recover_on_interrupt)
      doze_enable_bit      <= 1'b0;
    else if (isr_entry_in && recover_on_interrupt)
      doze_enable_bit      <= 1'b0;
  end

  assign doze_active_out = doze_enable_bit;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= 8'h00;
    else if (rd_in)
      case (addr_in)
        `SIC_REG_REGULATOR: rdata_out <= {6'h00, regulator_power_mode, 1'b0};
        `SIC_REG_DOZE_IDLE: rdata_out <= {idle_select, doze_enable_bit,
                                          recover_on_interrupt, doze_on_exit,
                                          1'b0, doze_ratio};
        `SIC_REG_STATUS:    rdata_out <= {5'h00, 3'(state)};
        default:            rdata_out <= 8'h00;
      endcase
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_nop_sleep_stays: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_RUN && sleep_exec_in && wake_int && !global_int_enable_in
    |=> state == SIC_RUN) else $error("sleep not a no-op");
  a_sleep_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_RUN && next_state == SIC_SLEEP
    |=> !powerdown_flag_out && timeout_flag_out) else $error("bad flags");
  a_idle_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_RUN && next_state != SIC_RUN
    |=> state == (idle_select ? SIC_IDLE : SIC_SLEEP))
    else $error("wrong mode");
  a_idle_int_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_IDLE && wake_int |=> state == SIC_RESUME ##1 state == SIC_RUN)
    else $error("idle not ended");
  a_wdt_clear_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_SLEEP && next_state != SIC_SLEEP |=> watchdog_clear_out)
    else $error("no wdt clear");
  a_idle_wdt_block: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_IDLE |-> !watchdog_reset_out) else $error("wdt reset");
  a_idle_cpu_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_IDLE && $past(state) == SIC_IDLE
    |-> !clk_ctrl_out.clk_cpu_en && clk_ctrl_out.clk_sys_en)
    else $error("idle clocks");
  a_vector_gie: assert property (@(posedge clk_in) disable iff (!resetn_in)
    vector_req_out |-> gie_at_wake && int_wake && resume_out)
    else $error("bad vector");
  a_clkswitch_excl: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state == SIC_SLEEP && clkswitch_int_in && !wdt_sync2 |=> state == SIC_SLEEP)
    else $error("clock switch woke");

endmodule

// ==== sic_core_model.sv ====
// Model of the core, one interrupt source and the windowed watchdog.
`timescale 1ns/10ps
module sic_core_model (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // From the controller
  input  wire logic vector_req_in,
  input  wire logic powerdown_flag_in,
  // To the controller
  output logic      sleep_exec_out,
  output logic      gie_out,
  output logic      int_pending_out,
  output logic      clkswitch_out,
  output logic      isr_entry_out,
  output logic      windowed_watchdog_out
);
  logic int_flag;
  logic int_enable;

  initial
  begin
    {sleep_exec_out, gie_out, clkswitch_out, windowed_watchdog_out} = 4'h0;
    {int_flag, int_enable} = 2'h0;
  end

  // Only a source whose own enable is set may ask for a wake.
  assign int_pending_out = int_flag & int_enable;

  // The core enters its service routine after the resume instruction.
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      isr_entry_out <= 1'b0;
    else
      isr_entry_out <= vector_req_in;

  task automatic sleep_op;
    @(posedge clk_in);
    sleep_exec_out <= 1'b1;
    @(posedge clk_in);
    sleep_exec_out <= 1'b0;
  endtask

  // Software learns from this flag whether the sleep really happened.
  function automatic logic slept();
    return !powerdown_flag_in;
  endfunction
endmodule

// ==== sleep_idle_wakeup_control_tb.sv ====
// Self-checking testbench for the power-mode controller.
`timescale 1ns/10ps
module sleep_idle_wakeup_control_tb;
  import sic_pkg::*;
  localparam int OST = 8;
  localparam int LP  = 16;
  logic          clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
  logic [11:0]   addr_in = '0;
  logic [7:0]    wdata_in = '0, rdata_out, rd;
  logic          crystal_mode_in = 0, clock_output_enable_n_in = 0;
  logic          sleep_exec, global_int_enable, int_pending, clkswitch, isr_entry, windowed_watchdog;
  logic          powerdown_flag_out, timeout_flag_out, prefetch_out;
  logic          vector_req_out, resume_out, watchdog_clear_out;
  logic          watchdog_reset_out, doze_active_out;
  logic [14:0]   vector_addr_out;
  sic_clk_ctrl_t clk_ctrl_out;
  int            failures = 0, checks_done = 0, cycles = 0, wdc = 0;
  int            base, lat0, lat1, lat2;
  logic [27:0]   rows [4] = '{{12'h812, 8'h02, 8'h02}, {12'h88c, 8'h80, 8'h80},
                              {12'h88c, 8'h00, 8'h00}, {12'h123, 8'h5a, 8'h00}};

  always #25 clk_in = ~clk_in;

  sic_power_ctrl #(.OST_CYCLES(OST), .LP_CYCLES(LP), .REGULATED(1'b1))
    sic_power_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sleep_exec_in(sleep_exec),
    .global_int_enable_in(global_int_enable), .int_pending_in(int_pending),
    .clkswitch_int_in(clkswitch), .isr_entry_in(isr_entry),
    .powerdown_flag_out(powerdown_flag_out),
    .timeout_flag_out(timeout_flag_out), .prefetch_out(prefetch_out),
    .vector_req_out(vector_req_out), .vector_addr_out(vector_addr_out),
    .resume_out(resume_out), .windowed_watchdog_in(windowed_watchdog),
    .crystal_mode_in(crystal_mode_in),
    .clock_output_enable_n_in(clock_output_enable_n_in),
    .watchdog_clear_out(watchdog_clear_out),
    .watchdog_reset_out(watchdog_reset_out), .clk_ctrl_out(clk_ctrl_out),
    .doze_active_out(doze_active_out));

  sic_core_model core_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .vector_req_in(vector_req_out), .powerdown_flag_in(powerdown_flag_out),
    .sleep_exec_out(sleep_exec), .gie_out(global_int_enable), .int_pending_out(int_pending),
    .clkswitch_out(clkswitch), .isr_entry_out(isr_entry), .windowed_watchdog_out(windowed_watchdog));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang is cut short well beyond the 135 or so cycles needed.
  always @(posedge clk_in)
  begin
    cycles++;
    if (watchdog_clear_out === 1'b1)
      wdc++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rdreg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Returns just after the edge at which the controller takes the sleep.
  task automatic do_sleep;
    base = wdc;
    core_inst.sleep_op();
    #1;
  endtask

  // Raises an enabled interrupt and measures cycles until the core resumes.
  task automatic wake_int(input logic g, output int n);
    @(posedge clk_in);
    core_inst.gie_out <= g;
    core_inst.int_flag <= 1'b1;
    core_inst.int_enable <= 1'b1;
    n = 0;
    while (resume_out !== 1'b1 && n < 2000)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    check("vector_req", vector_req_out, g);
    check("vector_addr", vector_addr_out, 15'h0004);
    @(posedge clk_in);
    core_inst.int_flag <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    check("powerdown_rst", powerdown_flag_out, 1'b1);
    check("clk_ctrl_rst", clk_ctrl_out, 4'he);
    foreach (rows[i])
    begin
      wr(rows[i][27:16], rows[i][15:8]);
      rdreg(rows[i][27:16], rd);
      check("register", rd, rows[i][7:0]);
    end
    wr(12'h812, 8'h00);
    // Pending enabled interrupt with global enable clear: no sleep.
    @(posedge clk_in);
    core_inst.int_flag <= 1'b1;
    core_inst.int_enable <= 1'b1;
    do_sleep();
    repeat (3) @(posedge clk_in);
    #1 check("noop_pd", powerdown_flag_out, 1'b1);
    check("noop_cpu", clk_ctrl_out.clk_cpu_en, 1'b1);
    check("noop_wdt", wdc - base, 0);
    check("noop_slept", core_inst.slept(), 1'b0);
    // Flag set but source disabled: the device must really sleep.
    core_inst.int_enable <= 1'b0;
    do_sleep();
    check("prefetch", prefetch_out, 1'b1);
    check("pd_sleep", powerdown_flag_out, 1'b0);
    check("to_sleep", timeout_flag_out, 1'b1);
    check("clk_sleep", clk_ctrl_out, 4'h0);
    repeat (6) @(posedge clk_in);
    #1 check("no_wake", clk_ctrl_out.clk_cpu_en, 1'b0);
    base = wdc;
    wake_int(1'b1, lat0);
    check("wdt_clear", wdc > base, 1'b1);
    check("cpu_back", clk_ctrl_out.clk_cpu_en, 1'b1);
    // Crystal start-up and low-power regulator wake delays.
    crystal_mode_in <= 1'b1;
    do_sleep();
    wake_int(1'b0, lat1);
    check("ost_delay", 16'(lat1 - lat0), 16'(OST));
    crystal_mode_in <= 1'b0;
    wr(12'h812, 8'h02);
    do_sleep();
    check("lp_sleep", clk_ctrl_out.reg_lowpower, 1'b1);
    wake_int(1'b0, lat2);
    check("lp_delay", 16'(lat2 - lat0), 16'(LP));
    wr(12'h812, 8'h00);
    // The clock switch interrupt must not turn sleep into a no-operation.
    @(posedge clk_in);
    core_inst.clkswitch_out <= 1'b1;
    core_inst.int_flag <= 1'b1;
    core_inst.int_enable <= 1'b1;
    do_sleep();
    check("clksw_sleep", clk_ctrl_out.clk_cpu_en, 1'b0);
    core_inst.clkswitch_out <= 1'b0;
    core_inst.int_flag <= 1'b0;
    wake_int(1'b0, lat1);
    // Idle keeps peripheral and output clocks running.
    wr(12'h88c, 8'h80);
    do_sleep();
    check("idle_clk", clk_ctrl_out[3:1], 3'h3);
    wake_int(1'b0, lat1);
    rdreg(12'h88c, rd);
    check("idle_kept", rd, 8'h80);
    // Watchdog in idle wakes instead of resetting.
    wr(12'h88c, 8'hc0);
    do_sleep();
    core_inst.windowed_watchdog_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check("windowed_watchdog_idle", watchdog_reset_out, 1'b0);
    check("windowed_watchdog_woke", clk_ctrl_out.clk_cpu_en, 1'b1);
    core_inst.windowed_watchdog_out <= 1'b0;
    rdreg(12'h88c, rd);
    check("doze_enable_bit_kept", rd, 8'hc0);
    @(posedge clk_in);
    core_inst.windowed_watchdog_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 check("windowed_watchdog_run", watchdog_reset_out, 1'b1);
    core_inst.windowed_watchdog_out <= 1'b0;
    // Recover-on-interrupt leaves doze when the interrupt ends idle.
    wr(12'h88c, 8'he0);
    do_sleep();
    check("doze_on", doze_active_out, 1'b1);
    wake_int(1'b1, lat1);
    repeat (3) @(posedge clk_in);
    #1 check("doze_off", doze_active_out, 1'b0);
    give_verdict();
  end
endmodule
